// ---- rtl/ftoc_config_bank.sv ----
// fan pulse-count and temperature-format/overtemp-output config registers
//
// Behaviour
// - fan A pulses per measurement from bits 1:0, codes give 1 to 4.
// - fans B, C, D use same encoding in bits 3:2, 5:4, 7:6.
// - pulse-count register resets to 0x55, two pulses per fan.
// - config bit 0 selects twos complement (1) or offset-64 (0); reset 0x01.
// - format change reinterprets all temperatures and limits at once.
// - config bit 1 sets offset resolution 0.5 or 1 degree for three offsets.
// - cpu temperature offset always uses 1 degree resolution.
// - bit 4 drives overtemp pin when cpu reading exceeds cpu control limit.
// - bit 5 drives overtemp pin when remote A exceeds its limit.
// - bit 6 drives overtemp pin when local exceeds its limit.
// - disabled source never drives pin; pin then only an input to the timer.
// - limit of -64 (offset-64) or -128 (twos) disables that source.
// - lock bit makes the config register read-only; writes ignored.
// - global disable suppresses overtemp output on every source.
`timescale 1ns/10ps
`include "ftoc_defs.svh"
module ftoc_config_bank (
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_i,
  input  wire ftoc_pkg::ftoc_reg_req_t  req_i,
  output logic [7:0]                    rdata_o,
  output logic                          rvalid_o,
  input  wire logic                     lock_i,
  input  wire logic                     overtemp_global_disable_i,
  input  wire ftoc_pkg::ftoc_temps_t    temps_i,
  input  wire ftoc_pkg::ftoc_temps_t    limits_i,
  output ftoc_pkg::ftoc_pulse_cfg_t     pulse_cfg_o,
  output logic [2:0]                    fan_a_pulse_count_o,
  output logic [2:0]                    fan_b_pulse_count_o,
  output logic [2:0]                    fan_c_pulse_count_o,
  output logic [2:0]                    fan_d_pulse_count_o,
  output logic                          temp_format_select_o,
  output logic                          offset_half_step_o,
  output logic                          cpu_offset_half_step_o,
  input  wire logic                     overtemp_pin_i,
  output logic                          overtemp_pin_o,
  output logic                          overtemp_pin_oe_n_o,
  output logic                          overtemp_timer_in_o
);
  logic [7:0] pulse_ff;
  logic [7:0] nxt_pulse;
  logic [7:0] cfg_ff;
  logic [7:0] nxt_cfg;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic       rvalid_ff;
  logic       nxt_rvalid;
  logic       drive_ff;
  logic       nxt_drive;
  logic [`FTOC_NUM_SRC-1:0] trip;
  logic [`FTOC_NUM_SRC-1:0] src_en;
  logic [2:0] cnt [`FTOC_NUM_FANS];

  // register writes and reads
  always_comb begin
    nxt_pulse = pulse_ff;
    nxt_cfg = cfg_ff;
    nxt_rdata = rdata_ff;
    nxt_rvalid = req_i.rd_en;
    if (req_i.wr_en && req_i.addr == `FTOC_ADDR_PULSE_COUNT) begin
      nxt_pulse = req_i.wdata;
    end
    if (req_i.wr_en && req_i.addr == `FTOC_ADDR_TEMP_CONFIG && !lock_i) begin
      nxt_cfg = req_i.wdata;
    end
    if (req_i.rd_en) begin
      case (req_i.addr)
        `FTOC_ADDR_PULSE_COUNT: nxt_rdata = pulse_ff;
        `FTOC_ADDR_TEMP_CONFIG: nxt_rdata = cfg_ff;
        default:                nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pulse_ff  <= `FTOC_RST_PULSE_COUNT;
      cfg_ff    <= `FTOC_RST_TEMP_CONFIG;
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      pulse_ff  <= nxt_pulse;
      cfg_ff    <= nxt_cfg;
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // pulse code to pulse count, one per fan
  genvar g;
  generate
    for (g = 0; g < `FTOC_NUM_FANS; g++) begin : g_fan
      assign cnt[g] = {1'b0, pulse_ff[2*g+1 -: 2]} + 3'h1;
    end
  endgenerate

  assign src_en = {cfg_ff[`FTOC_BIT_REMOTE_B_OE], cfg_ff[`FTOC_BIT_LOCAL_OE],
                   cfg_ff[`FTOC_BIT_REMOTE_A_OE], cfg_ff[`FTOC_BIT_CPU_OE]};

  // one comparator per source; source 0 (cpu) sits in the top byte
  genvar s;
  generate
    for (s = 0; s < `FTOC_NUM_SRC; s++) begin : g_src
      ftoc_src_cmp u_cmp (
        .twos_i   (cfg_ff[`FTOC_BIT_FORMAT]),
        .enable_i (src_en[s]),
        .temp_i   (temps_i[8*`FTOC_NUM_SRC-1-8*s -: 8]),
        .limit_i  (limits_i[8*`FTOC_NUM_SRC-1-8*s -: 8]),
        .trip_o   (trip[s])
      );
    end
  endgenerate

  // pin drive decision, registered
  always_comb begin
    nxt_drive = (|trip) && !overtemp_global_disable_i;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      drive_ff <= 1'b0;
    end else begin
      drive_ff <= nxt_drive;
    end
  end

  assign rdata_o                = rdata_ff;
  assign rvalid_o               = rvalid_ff;
  assign pulse_cfg_o            = pulse_ff;
  assign fan_a_pulse_count_o    = cnt[0];
  assign fan_b_pulse_count_o    = cnt[1];
  assign fan_c_pulse_count_o    = cnt[2];
  assign fan_d_pulse_count_o    = cnt[3];
  assign temp_format_select_o   = cfg_ff[`FTOC_BIT_FORMAT];
  assign offset_half_step_o     = !cfg_ff[`FTOC_BIT_OFFSET_RANGE];
  assign cpu_offset_half_step_o = 1'b0;
  // open drain: drives low (active overtemp), oe low while driving
  assign overtemp_pin_o         = 1'b0;
  assign overtemp_pin_oe_n_o    = !drive_ff;
  assign overtemp_timer_in_o    = overtemp_pin_i;
endmodule

// ---- pkg/ftoc_defs.svh ----
// register offsets, field positions, reset values and codes for the fan/overtemp config bank
`ifndef FTOC_DEFS_SVH
`define FTOC_DEFS_SVH
`define FTOC_ADDR_PULSE_COUNT   8'h7B
`define FTOC_ADDR_TEMP_CONFIG   8'h7C
`define FTOC_RST_PULSE_COUNT    8'h55
`define FTOC_RST_TEMP_CONFIG    8'h01
`define FTOC_BIT_FORMAT         0
`define FTOC_BIT_OFFSET_RANGE   1
`define FTOC_BIT_CPU_OE         4
`define FTOC_BIT_REMOTE_A_OE    5
`define FTOC_BIT_LOCAL_OE       6
`define FTOC_BIT_REMOTE_B_OE    7
`define FTOC_LIMIT_OFF_OFFSET64 8'h00
`define FTOC_LIMIT_OFF_TWOS     8'h80
`define FTOC_NUM_FANS           4
`define FTOC_NUM_SRC            4
`endif

// ---- pkg/ftoc_pkg.sv ----
// types for the fan/overtemp config bank
package ftoc_pkg;
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ftoc_reg_req_t;

  typedef struct packed {
    logic [7:0] cpu;
    logic [7:0] remote_a;
    logic [7:0] local_t;
    logic [7:0] remote_b;
  } ftoc_temps_t;

  typedef struct packed {
    logic [1:0] fan_d_pulse_count;
    logic [1:0] fan_c_pulse_count;
    logic [1:0] fan_b_pulse_count;
    logic [1:0] fan_a_pulse_count;
  } ftoc_pulse_cfg_t;
endpackage

// ---- rtl/ftoc_src_cmp.sv ----
// one temperature source: format-aware compare against its limit
`timescale 1ns/10ps
`include "ftoc_defs.svh"
module ftoc_src_cmp (
  input  wire logic       twos_i,
  input  wire logic       enable_i,
  input  wire logic [7:0] temp_i,
  input  wire logic [7:0] limit_i,
  output logic            trip_o
);
  logic       limit_off;
  logic [7:0] t_cmp;
  logic [7:0] l_cmp;

  // offset-64 values are unsigned; flip msb on twos values to compare unsigned
  always_comb begin
    t_cmp = twos_i ? {~temp_i[7], temp_i[6:0]} : temp_i;
    l_cmp = twos_i ? {~limit_i[7], limit_i[6:0]} : limit_i;
    limit_off = twos_i ? (limit_i == `FTOC_LIMIT_OFF_TWOS)
                       : (limit_i == `FTOC_LIMIT_OFF_OFFSET64);
    trip_o = enable_i && !limit_off && (t_cmp > l_cmp);
  end
endmodule

// ---- verif/ftoc_host_model.sv ----
// host register-bus driver for the config bank
`timescale 1ns/10ps
module ftoc_host_model (
  input  wire logic               clk_sys_i,
  input  wire logic [7:0]         rdata_i,
  output ftoc_pkg::ftoc_reg_req_t req_o
);
  initial req_o = '0;
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge clk_sys_i);
    req_o = '{w, !w, a, d};
    @(negedge clk_sys_i);
    req_o = '0;
    q = rdata_i;
  endtask
endmodule

// ---- verif/ftoc_config_bank_assertions.sv ----
// port checks for the config bank
`timescale 1ns/10ps
module ftoc_config_bank_assertions (
  input wire logic                      clk_sys_i,
  input wire logic                      rst_i,
  input wire ftoc_pkg::ftoc_reg_req_t   req_i,
  input wire logic [7:0]                rdata_o,
  input wire logic                      rvalid_o,
  input wire logic                      lock_i,
  input wire logic                      overtemp_global_disable_i,
  input wire ftoc_pkg::ftoc_pulse_cfg_t pulse_cfg_o,
  input wire logic [2:0]                fan_a_pulse_count_o,
  input wire logic [2:0]                fan_d_pulse_count_o,
  input wire logic                      temp_format_select_o,
  input wire logic                      offset_half_step_o,
  input wire logic                      cpu_offset_half_step_o,
  input wire logic                      overtemp_pin_oe_n_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wire cfg_wr = req_i.wr_en && req_i.addr == 8'h7C;
  pulse_read_a: assert property (req_i.rd_en && req_i.addr == 8'h7B |=>
    rvalid_o && rdata_o == $past(pulse_cfg_o)) else $error("pulse read");
  fan_a_cnt_a: assert property (fan_a_pulse_count_o ==
    {1'b0, pulse_cfg_o.fan_a_pulse_count} + 3'h1) else $error("fan a count");
  fan_d_cnt_a: assert property (fan_d_pulse_count_o ==
    {1'b0, pulse_cfg_o.fan_d_pulse_count} + 3'h1) else $error("fan d count");
  format_wr_a: assert property (cfg_wr && !lock_i |=>
    temp_format_select_o == $past(req_i.wdata[0])) else $error("format write");
  step_wr_a: assert property (cfg_wr && !lock_i |=>
    offset_half_step_o != $past(req_i.wdata[1])) else $error("step write");
  lock_hold_a: assert property (cfg_wr && lock_i |=>
    $stable(temp_format_select_o) && $stable(offset_half_step_o)) else $error("locked write");
  cpu_step_a: assert property (!cpu_offset_half_step_o) else $error("cpu step");
  global_off_a: assert property (overtemp_global_disable_i |=> overtemp_pin_oe_n_o)
    else $error("global disable");
endmodule
bind ftoc_config_bank ftoc_config_bank_assertions i_chk (.*);

// ---- verif/ftoc_config_bank_tb.sv ----
// self-checking bench for the config bank
`timescale 1ns/10ps
module ftoc_config_bank_tb;
  logic                    clk_sys_i = 0, rst_i = 1, lock_i = 0, gd = 0, pin = 0, oe_n, e;
  logic                    ti, po;
  logic [31:0]             tv = '0, lv = '0;
  logic [7:0]              rdata, rd, t, l, c, pc = 8'h55, cf = 8'h01;
  logic [11:0]             fc;
  ftoc_pkg::ftoc_reg_req_t req;
  int                      num_errors = 0, checked = 0;
  initial forever #4 clk_sys_i = ~clk_sys_i;
  ftoc_host_model i_host (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .req_o(req));
  ftoc_config_bank i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata),
    .rvalid_o(), .lock_i(lock_i), .overtemp_global_disable_i(gd), .temps_i(tv),
    .limits_i(lv), .pulse_cfg_o(), .fan_a_pulse_count_o(fc[2:0]),
    .fan_b_pulse_count_o(fc[5:3]), .fan_c_pulse_count_o(fc[8:6]),
    .fan_d_pulse_count_o(fc[11:9]), .temp_format_select_o(), .offset_half_step_o(),
    .cpu_offset_half_step_o(), .overtemp_pin_i(pin), .overtemp_pin_o(po),
    .overtemp_pin_oe_n_o(oe_n), .overtemp_timer_in_o(ti));
  task automatic chk(input string n, input logic [7:0] x, s);
    checked++;
    if (s !== x) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, x, s);
    end
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    finish_test;
  end
  initial begin
    void'($urandom(32'hA868));
    repeat (4) @(posedge clk_sys_i);
    @(negedge clk_sys_i) rst_i = 0;
    i_host.xfer(0, 8'h7B, 0, rd);
    chk("pulse", pc, rd);
    i_host.xfer(0, 8'h7C, 0, rd);
    chk("cfg", cf, rd);
    i_host.xfer(0, 8'h7D, 0, rd);
    chk("unmapped", 8'h00, rd);
    repeat (200) begin
      c = 8'($urandom);
      i_host.xfer(1, 8'h7B, c, rd);
      pc = c;
      i_host.xfer(0, 8'h7B, 0, rd);
      chk("pulse", pc, rd);
      for (int k = 0; k < 4; k++) chk("fan", 8'(pc[2*k+:2]) + 8'h1, 8'(fc[3*k+:3]));
      lock_i = ($urandom % 4) == 0;
      c = 8'($urandom);
      i_host.xfer(1, 8'h7C, c, rd);
      if (!lock_i) cf = c;
      i_host.xfer(0, 8'h7C, 0, rd);
      chk("cfg", cf, rd);
      gd = ($urandom % 4) == 0;
      tv = $urandom;
      lv = $urandom;
      lv[31-8*($urandom%4) -: 8] = cf[0] ? 8'h80 : 8'h00;
      pin = 1'($urandom);
      @(negedge clk_sys_i);
      e = 0;
      for (int k = 0; k < 4; k++) begin
        t = tv[31-8*k -: 8];
        l = lv[31-8*k -: 8];
        if (cf[4+k] && !gd && l != (cf[0] ? 8'h80 : 8'h00) &&
            (cf[0] ? $signed(t) > $signed(l) : t > l)) e = 1;
      end
      chk("oe_n", 8'(!e), 8'(oe_n));
      chk("timer_in", 8'(pin), 8'(ti));
      chk("pin_o", 8'h00, 8'(po));
    end
    finish_test;
  end
endmodule
